// ### dsm_consts.svh
`ifndef DSM_CONSTS_SVH
`define DSM_CONSTS_SVH
// ****************************************
// command word fields
// ****************************************
`define DSM_CW_SWITCH_ON     0
`define DSM_CW_EN_VOLTAGE    1
`define DSM_CW_QUICK_STOP_N  2
`define DSM_CW_EN_OPERATION  3
`define DSM_CW_FAULT_RESET   7
`define DSM_CW_HALT          8
// ****************************************
// state word fields
// ****************************************
`define DSM_SW_READY         0
`define DSM_SW_SWITCHED_ON   1
`define DSM_SW_OP_ENABLED    2
`define DSM_SW_FAULT         3
`define DSM_SW_VOLTAGE       4
`define DSM_SW_QUICK_STOP_N  5
`define DSM_SW_SON_DISABLED  6
`define DSM_SW_WARNING       7
`define DSM_SW_REMOTE        9
`define DSM_SW_TARGET        10
`define DSM_SW_LIMIT         11
`define DSM_SW_WARNING2      15
// ****************************************
// modes and reset values
// ****************************************
`define DSM_SRC_BUS          2'd1
`define DSM_T5_COAST         2'd0
`define DSM_T5_DCBRAKE       2'd1
`define DSM_T5_RAMP          2'd2
`define DSM_CMD_RESET        16'h0000
`define DSM_SW_RESET         16'h0040
`define DSM_BRAKE_TIME_NS    1000
`define DSM_CLK_PERIOD_NS    5
`define DSM_BRAKE_CYCLES     (`DSM_BRAKE_TIME_NS / `DSM_CLK_PERIOD_NS)
`endif

// ### dsm_pkg.sv
package dsm_pkg;
  // drive states
  typedef enum logic [2:0] {
    DSM_SOD      = 3'b000,
    DSM_READY    = 3'b001,
    DSM_SON      = 3'b010,
    DSM_OPEN     = 3'b011,
    DSM_QSTOP    = 3'b100,
    DSM_FREACT   = 3'b101,
    DSM_FAULT    = 3'b110
  } dsm_state_t;

  // plant status inputs travelling together
  typedef struct packed {
    logic mains_ok;
    logic warning;
    logic warning_trip;
    logic limit_active;
    logic at_reference;
    logic pfail_zero;
    logic fault_cause;
    logic standstill;
  } dsm_plant_t;
endpackage : dsm_pkg

// ### dsm_brake_timer.sv
`timescale 1ns/1ps
`include "dsm_consts.svh"
// ****************************************
// dc brake hold-off timer
// ****************************************
module dsm_brake_timer
  import dsm_pkg::*;
#(
  parameter int CYCLES = `DSM_BRAKE_CYCLES
)(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_r;

  // counts down once started; done pulses on the last cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_r <= '0;
    else if (start && cnt_r == '0)
      cnt_r <= W'(CYCLES);
    else if (cnt_r != '0)
      cnt_r <= cnt_r - W'(1);
  end

  assign busy = (cnt_r != '0);
  assign done = (cnt_r == W'(1));
endmodule : dsm_brake_timer

// ### dsm_drive_state_machine.sv
`timescale 1ns/1ps
`include "dsm_consts.svh"
// Overview of operation
// - source select equal 1 makes the bus command word drive the state machine
// - motion control: enabling operation needs both safety releases
// - no motion control: enabling also needs a start input
// - leaving operation enabled coasts, ramps or dc brakes per setting; motion control always coasts
// - halt counts only in motion control; bits 4,5,6 are not decoded
// - state bit 4 mirrors mains; no switch-on without it
// - switch-on only while voltage present bit set
// - direct ready-to-enabled jump only without motion control and with mains
// - command bits decoded into shutdown, switch on, enable, quick stop, fault reset
// - state encoded on state word bits 6,5,3,2,1,0
// - warning bit may rise any time; cause read separately
// - remote bit set only with bus control and hardware release
// - bus writes accepted whenever source select is 1 and no dc brake runs; releases and start inputs not checked
// - motion control release needs both safety releases and digital input one
// - target reached within hysteresis, or power fail regulation at zero
// - without motion control target compares against target velocity
// - bit 11 set while any internal limit is active
// - bit 15 set on warnings preceding a fault trip
// - dc brake stop ignores new commands until braking ends
// - ramp stop returns to enabled when enable reissued
module dsm_drive_state_machine
  import dsm_pkg::*;
#(
  parameter int BRAKE_CYCLES = `DSM_BRAKE_CYCLES
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // command word port
  input  wire logic        cmd_we,
  input  wire logic [15:0] cmd_wdata,
  output logic      [15:0] drive_command_word,
  output logic      [15:0] drive_state_word,
  // configuration
  input  wire logic [1:0]  control_source,
  input  wire logic        motion_control,
  input  wire logic [1:0]  transition5_mode,
  // hardware inputs
  input  wire logic        safety_release_a,
  input  wire logic        safety_release_b,
  input  wire logic        digital_input_one,
  input  wire logic        start_clockwise_input,
  input  wire logic        start_anticlockwise_input,
  // plant status
  input  wire dsm_plant_t  plant,
  // drive outputs
  output logic             power_stage_on,
  output logic             ramp_stop_active,
  output logic             dc_brake_active,
  output logic             halt_active
);
  // ****************************************
  // registers
  // ****************************************
  logic [15:0] cmd_r;
  logic        fr_prev_r;
  dsm_state_t  state_r;
  dsm_state_t  state_nxt;
  logic [15:0] sw_r;
  logic        ramp_r;
  logic        pwr_r;
  logic        brk_r;
  logic        halt_r;

  // ****************************************
  // release and command decode
  // ****************************************
  wire bus_ctl    = (control_source == `DSM_SRC_BUS);
  wire sto_ok     = safety_release_a & safety_release_b;
  wire start_any  = start_clockwise_input | start_anticlockwise_input;
  // motion control needs both safety releases and input one; start inputs ignored there
  wire release_ok = motion_control ? (sto_ok & digital_input_one)
                                   : (sto_ok & start_any);
  wire enable_ok  = motion_control ? sto_ok : (sto_ok & start_any);
  wire mains      = plant.mains_ok;
  wire brake_busy;
  wire brake_done;
  wire c_sw  = cmd_r[`DSM_CW_SWITCH_ON];
  wire c_ev  = cmd_r[`DSM_CW_EN_VOLTAGE];
  wire c_qs  = cmd_r[`DSM_CW_QUICK_STOP_N];
  wire c_eo  = cmd_r[`DSM_CW_EN_OPERATION];
  wire cmd_disable_v = ~c_ev;
  wire cmd_quick     = c_ev & ~c_qs;
  wire cmd_shutdown  = c_ev & c_qs & ~c_sw;
  wire cmd_switch_on = c_ev & c_qs & c_sw & ~c_eo;
  wire cmd_enable    = c_ev & c_qs & c_sw & c_eo;
  wire fr_edge       = cmd_r[`DSM_CW_FAULT_RESET] & ~fr_prev_r;
  wire halt_req      = motion_control & cmd_r[`DSM_CW_HALT];
  wire fault_now     = plant.fault_cause;
  // brake start cycle; a write landing in that same cycle is refused too
  wire brake_start   = (state_r == DSM_OPEN) && cmd_switch_on && !motion_control &&
                       (transition5_mode == `DSM_T5_DCBRAKE) && !brk_r;
  // dc braking locks the command word so a stop runs to completion
  wire cmd_lock      = brake_start | brake_busy | brk_r;
  wire cmd_take      = cmd_we & bus_ctl & ~cmd_lock;

  // ****************************************
  // command word register
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_r     <= `DSM_CMD_RESET;
      fr_prev_r <= 1'b0;
    end
    else
    begin
      if (cmd_take)
        cmd_r <= cmd_wdata;
      fr_prev_r <= cmd_r[`DSM_CW_FAULT_RESET];
    end
  end

  // ****************************************
  // brake timer
  // ****************************************
  dsm_brake_timer #(
    .CYCLES (BRAKE_CYCLES)
  ) u_brake (
    .clk   (clk),
    .rst   (rst),
    .start (brake_start),
    .busy  (brake_busy),
    .done  (brake_done)
  );

  // ****************************************
  // state transitions
  // ****************************************
  always_comb
  begin
    state_nxt = state_r;
    if (!bus_ctl)
      state_nxt = (state_r == DSM_FAULT) ? DSM_FAULT : DSM_SOD;
    else if (fault_now && state_r != DSM_FAULT && state_r != DSM_FREACT)
      state_nxt = DSM_FREACT;
    else
    begin
      case (state_r)
        DSM_SOD:
          if (cmd_shutdown)
            state_nxt = DSM_READY;
        DSM_READY:
          if (cmd_disable_v || cmd_quick)
            state_nxt = DSM_SOD;
          else if (cmd_switch_on && mains)
            state_nxt = DSM_SON;
          else if (cmd_enable && mains && !motion_control && enable_ok && release_ok)
            state_nxt = DSM_OPEN;
        DSM_SON:
          if (cmd_disable_v || cmd_quick)
            state_nxt = DSM_SOD;
          else if (cmd_shutdown)
            state_nxt = DSM_READY;
          else if (cmd_enable && enable_ok && release_ok)
            state_nxt = DSM_OPEN;
        DSM_OPEN:
          if (brk_r)
          begin
            if (brake_done)
              state_nxt = DSM_SON;
          end
          else if (cmd_disable_v)
            state_nxt = DSM_SOD;
          else if (cmd_quick)
            state_nxt = DSM_QSTOP;
          else if (cmd_shutdown)
            state_nxt = DSM_READY;
          else if (cmd_switch_on)
          begin
            // coast leaves at once; ramp waits for standstill
            if (transition5_mode == `DSM_T5_COAST || motion_control)
              state_nxt = DSM_SON;
            else if (transition5_mode == `DSM_T5_RAMP && plant.standstill)
              state_nxt = DSM_SON;
          end
        DSM_QSTOP:
          if (cmd_disable_v || plant.standstill)
            state_nxt = DSM_SOD;
        DSM_FREACT:
          state_nxt = DSM_FAULT;
        DSM_FAULT:
          if (fr_edge && !fault_now)
            state_nxt = DSM_SOD;
        default:
          state_nxt = DSM_SOD;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_r <= DSM_SOD;
    else
      state_r <= state_nxt;
  end

  // ****************************************
  // stop behaviour flags
  // ****************************************
  // ramp drops back when enable reissued, brake holds until timer ends
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ramp_r <= 1'b0;
      brk_r  <= 1'b0;
    end
    else
    begin
      ramp_r <= (state_nxt == DSM_OPEN) && cmd_switch_on && !motion_control &&
                (transition5_mode == `DSM_T5_RAMP);
      if (state_nxt != DSM_OPEN)
        brk_r <= 1'b0;
      else if (state_r == DSM_OPEN && cmd_switch_on && !motion_control &&
               transition5_mode == `DSM_T5_DCBRAKE)
        brk_r <= 1'b1;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  wire [5:0] enc = (state_nxt == DSM_SOD)    ? 6'h20 :
                   (state_nxt == DSM_READY)  ? 6'h11 :
                   (state_nxt == DSM_SON)    ? 6'h13 :
                   (state_nxt == DSM_OPEN)   ? 6'h17 :
                   (state_nxt == DSM_QSTOP)  ? 6'h07 :
                   (state_nxt == DSM_FREACT) ? 6'h0f : 6'h08;
  wire [15:0] sw_nxt = {
    plant.warning_trip,
    3'h0,
    plant.limit_active,
    (plant.at_reference & ~motion_control) | plant.pfail_zero,
    bus_ctl & release_ok,
    1'b0,
    plant.warning,
    enc[5],
    enc[4],
    mains,
    enc[3:0]
  };

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sw_r   <= `DSM_SW_RESET;
      pwr_r  <= 1'b0;
      halt_r <= 1'b0;
    end
    else
    begin
      sw_r   <= sw_nxt;
      pwr_r  <= (state_nxt == DSM_OPEN) || (state_nxt == DSM_QSTOP);
      halt_r <= halt_req && (state_nxt == DSM_OPEN);
    end
  end

  assign drive_command_word = cmd_r;
  assign drive_state_word   = sw_r;
  assign power_stage_on     = pwr_r;
  assign ramp_stop_active   = ramp_r;
  assign dc_brake_active    = brk_r;
  assign halt_active        = halt_r;

  // ****************************************
  // checks
  // ****************************************
  property p_no_son_without_mains;
    @(posedge clk) disable iff (rst)
    (state_r == DSM_READY && !mains) |=> state_r != DSM_SON;
  endproperty
  a_no_son_without_mains: assert property (p_no_son_without_mains)
    else $error("switched on without mains");

  property p_enable_needs_release;
    @(posedge clk) disable iff (rst)
    (state_r != DSM_OPEN && state_nxt == DSM_OPEN) |-> sto_ok;
  endproperty
  a_enable_needs_release: assert property (p_enable_needs_release)
    else $error("enabled without safety release");

  property p_enable_needs_start;
    @(posedge clk) disable iff (rst)
    (!motion_control && state_r != DSM_OPEN && state_nxt == DSM_OPEN) |-> start_any;
  endproperty
  a_enable_needs_start: assert property (p_enable_needs_start)
    else $error("enabled without start input");

  property p_voltage_mirror;
    @(posedge clk) disable iff (rst)
    1'b1 |=> drive_state_word[`DSM_SW_VOLTAGE] == $past(mains);
  endproperty
  a_voltage_mirror: assert property (p_voltage_mirror)
    else $error("voltage bit not mirroring mains");

  property p_remote_bit;
    @(posedge clk) disable iff (rst)
    drive_state_word[`DSM_SW_REMOTE] |-> $past(bus_ctl) && $past(release_ok);
  endproperty
  a_remote_bit: assert property (p_remote_bit)
    else $error("remote bit without bus control");

  property p_brake_locks;
    @(posedge clk) disable iff (rst)
    brk_r && cmd_we |=> $stable(cmd_r);
  endproperty
  a_brake_locks: assert property (p_brake_locks)
    else $error("command taken during dc brake");

  property p_fault_reset;
    @(posedge clk) disable iff (rst)
    (state_r == DSM_FAULT && fault_now) |=> state_r == DSM_FAULT;
  endproperty
  a_fault_reset: assert property (p_fault_reset)
    else $error("fault left while cause remains");

  property p_limit_bit;
    @(posedge clk) disable iff (rst)
    plant.limit_active |=> drive_state_word[`DSM_SW_LIMIT];
  endproperty
  a_limit_bit: assert property (p_limit_bit)
    else $error("limit bit missing");

  property p_warn2_bit;
    @(posedge clk) disable iff (rst)
    plant.warning_trip |=> drive_state_word[`DSM_SW_WARNING2];
  endproperty
  a_warn2_bit: assert property (p_warn2_bit)
    else $error("warning 2 bit missing");

  property p_local_ignores;
    @(posedge clk) disable iff (rst)
    (!bus_ctl && cmd_we) |=> $stable(cmd_r);
  endproperty
  a_local_ignores: assert property (p_local_ignores)
    else $error("command taken outside bus control");
endmodule : dsm_drive_state_machine

// ### dsm_bus_master.sv
`timescale 1ns/1ps
// ****************************************
// bus master issuing command words
// ****************************************
module dsm_bus_master (
  // clock
  input  wire logic        clk,
  // command word port
  output logic             cmd_we,
  output logic [15:0]      cmd_wdata
);
  // idle at time zero
  initial
  begin
    cmd_we    = 1'b0;
    cmd_wdata = 16'h0000;
  end

  // one-cycle strobe, moved only at the falling edge
  task automatic send(input logic [15:0] w);
    @(negedge clk);
    cmd_we    = 1'b1;
    cmd_wdata = w;
    @(negedge clk);
    cmd_we    = 1'b0;
    cmd_wdata = ~w; // stale data must not look valid
  endtask : send
endmodule : dsm_bus_master

// ### test_drive_state_machine.sv
`timescale 1ns/1ps
// ****************************************
// bench for the drive state machine
// ****************************************
module test_drive_state_machine
  import dsm_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_we;
  logic [15:0] cmd_wdata, cmd_word, st_word, lc, r;
  logic [1:0]  src = 2'd1, tm = 2'd0;
  logic        mc = 1'b0, sa = 1'b1, sb = 1'b1, di1 = 1'b1, cw = 1'b0, acw = 1'b0;
  logic        pwr_o, ramp_o, brk_o, halt_o;
  dsm_plant_t  pl = '0;
  int          st = 0, seed = 4, cyc = 0, miscompares = 0, n_compared = 0;

  always #2.5 clk = ~clk;

  dsm_bus_master u_m (.clk(clk), .cmd_we(cmd_we), .cmd_wdata(cmd_wdata));

  dsm_drive_state_machine #(.BRAKE_CYCLES(4)) u_dsm_drive_state_machine (
    .clk(clk), .rst(rst), .cmd_we(cmd_we), .cmd_wdata(cmd_wdata),
    .drive_command_word(cmd_word), .drive_state_word(st_word),
    .control_source(src), .motion_control(mc), .transition5_mode(tm),
    .safety_release_a(sa), .safety_release_b(sb), .digital_input_one(di1),
    .start_clockwise_input(cw), .start_anticlockwise_input(acw), .plant(pl),
    .power_stage_on(pwr_o), .ramp_stop_active(ramp_o), .dc_brake_active(brk_o),
    .halt_active(halt_o));

  // reference model: next state from the command decode
  function automatic int nxt(input int s, input logic [15:0] c);
    logic rl;
    rl = sa && sb && (mc ? di1 : (cw || acw));
    if (s == 6)
      return (c[7] && !lc[7] && !pl.fault_cause) ? 0 : 6;
    if (!c[1])
      return 0;
    if (s == 4)
      return pl.standstill ? 0 : 4;
    if (!c[2])
      return (s == 3) ? 4 : 0; // quick stop
    if (c[2:0] == 3'b110)
      return (s == 0 || s == 2 || s == 3) ? 1 : s;
    if (s == 1 && c[3:0] == 4'h7 && pl.mains_ok)
      return 2;
    if (s == 1 && c[3:0] == 4'hf && pl.mains_ok && rl && !mc)
      return 3; // legacy direct jump
    if (s == 2 && c[3:0] == 4'hf && rl)
      return 3;
    if (s == 3 && c[3:0] == 4'h7 && (mc || tm == 2'd0 || (tm == 2'd2 && pl.standstill)))
      return 2;
    return s;
  endfunction : nxt

  // reference model: expected state word
  function automatic logic [15:0] exp_sw(input int s);
    logic [15:0] w;
    case (s)
      0: w = 16'h0040;
      1: w = 16'h0021;
      2: w = 16'h0023;
      3: w = 16'h0027;
      4: w = 16'h0007;
      default: w = 16'h0008;
    endcase
    w[4]  = pl.mains_ok;
    w[7]  = pl.warning;
    w[9]  = (src == 2'd1) && sa && sb && (mc ? di1 : (cw || acw));
    w[10] = (pl.at_reference && !mc) || pl.pfail_zero;
    w[11] = pl.limit_active;
    w[15] = pl.warning_trip;
    return w;
  endfunction : exp_sw

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
    n_compared++;
    if ((got & m) !== (exp & m))
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // quick-stop bit is free in fault
  task automatic sw();
    chk(st_word, exp_sw(st), (st == 6) ? 16'hffdf : 16'hffff);
  endtask : sw

  // write, let the two-cycle answer settle
  task automatic cmd(input logic [15:0] w);
    st = nxt(st, w);
    u_m.send(w);
    lc = w;
    repeat (3) @(negedge clk);
  endtask : cmd

  task automatic end_of_test();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    lc = 16'h0000;
    pl.mains_ok = 1'b1;
    repeat (12) @(negedge clk);
    chk(cmd_word, 16'h0000, 16'hffff);
    chk(st_word, 16'h0040, 16'hffff);
    rst = 1'b0;
    @(negedge clk);
    cmd(16'h0006);
    sw();
    chk(cmd_word, 16'h0006, 16'hffff);
    pl.mains_ok = 1'b0;
    cmd(16'h0007);
    sw();
    cmd(16'h000f);
    sw();
    pl.mains_ok = 1'b1;
    cmd(16'h0007);
    sw();
    cmd(16'h000f);
    sw();
    cw = 1'b1;
    cmd(16'h017f);
    sw();
    chk({15'h0000, halt_o}, 16'h0000, 16'hffff);
    chk({15'h0000, pwr_o}, 16'h0001, 16'hffff);
    cmd(16'h0107);
    sw();
    chk({15'h0000, pwr_o}, 16'h0000, 16'hffff);
    cmd(16'h0006);
    sw();
    cmd(16'h000f);
    sw();
    // dc brake: second write lands while braking
    tm = 2'd1;
    u_m.send(16'h0007);
    u_m.send(16'h0006);
    chk({15'h0000, brk_o}, 16'h0001, 16'hffff);
    repeat (14) @(negedge clk);
    st = 2;
    lc = 16'h0007;
    chk(cmd_word, 16'h0007, 16'hffff);
    sw();
    chk({15'h0000, brk_o}, 16'h0000, 16'hffff);
    // ramp stop: reissued enable keeps operation enabled
    tm = 2'd2;
    cmd(16'h000f);
    cmd(16'h0007);
    sw();
    chk({15'h0000, ramp_o}, 16'h0001, 16'hffff);
    cmd(16'h000f);
    sw();
    chk({15'h0000, ramp_o}, 16'h0000, 16'hffff);
    pl.standstill = 1'b1;
    cmd(16'h0007);
    sw();
    pl.standstill = 1'b0;
    tm = 2'd0;
    // status flag bits, one by one
    for (int i = 0; i < 5; i++)
    begin
      pl = '0;
      pl.mains_ok = 1'b1;
      pl[6 - i] = 1'b1;
      repeat (4) @(negedge clk);
      sw();
    end
    pl.pfail_zero = 1'b0;
    pl.fault_cause = 1'b1;
    repeat (4) @(negedge clk);
    st = 6;
    sw();
    cmd(16'h0080);
    sw();
    pl.fault_cause = 1'b0;
    cmd(16'h0000);
    cmd(16'h0080);
    sw();
    // motion control: start inputs ignored, halt honoured, quick stop
    mc = 1'b1;
    cw = 1'b0;
    cmd(16'h0006);
    cmd(16'h0007);
    cmd(16'h010f);
    sw();
    chk({15'h0000, halt_o}, 16'h0001, 16'hffff);
    cmd(16'h0007);
    sw();
    cmd(16'h000f);
    cmd(16'h000b);
    sw();
    chk({15'h0000, pwr_o}, 16'h0001, 16'hffff);
    pl.standstill = 1'b1;
    repeat (3) @(negedge clk);
    st = 0;
    sw();
    pl.standstill = 1'b0;
    mc = 1'b0;
    cw = 1'b1;
    // leaving bus control: writes refused
    src = 2'd0;
    st = 0;
    for (int i = 0; i < 3; i++)
    begin
      r = $random(seed);
      u_m.send(r);
      repeat (3) @(negedge clk);
      chk(cmd_word, lc, 16'hffff);
      sw();
    end
    end_of_test();
  end
endmodule : test_drive_state_machine
